// [hw/tmrs_consts.svh]
// constants of the timer register set: offsets, fields, resets, timings
// assumes inclusion by bare name from the top module
`ifndef TMRS_CONSTS_SVH
`define TMRS_CONSTS_SVH
// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define TMRS_IDX_COUNT      8'h01
`define TMRS_IDX_INTCTL_LO  8'h0b
`define TMRS_IDX_INTCTL_HI  8'h8b
`define TMRS_IDX_OPTIONS    8'h81
`define TMRS_IDX_DIR        8'h85
`define TMRS_IDX_CONTROL    8'hc0
`define TMRS_IDX_STATUS     8'hc1
`define TMRS_IDX_MASK       8'hc2
// interrupt control fields
`define TMRS_IC_OVF_EN      5
`define TMRS_IC_OVF_FLAG    2
`define TMRS_IC_RESET       8'h00
// option fields
`define TMRS_OPT_SRC        5
`define TMRS_OPT_EDGE       4
`define TMRS_OPT_ASSIGN     3
`define TMRS_OPT_RESET      8'hff
// direction register
`define TMRS_DIR_WIDTH      5
`define TMRS_DIR_RESET      5'h1f
// control register bits (write one to act, read zero)
`define TMRS_CTL_WD_CLEAR   0
`define TMRS_CTL_POR        1
// status / mask bits
`define TMRS_EV_OVF         0
`define TMRS_EV_WD          1
`define TMRS_EV_WIDTH       2
// watchdog base period
`define TMRS_WD_BASE_NS     18000000
`define TMRS_CLK_NS         100
`endif

// [hw/tmrs_pkg.sv]
// types shared by the timer register set
// assumes tmrs_consts.svh is on the include path
package tmrs_pkg;
   typedef enum logic [1:0] {
      TMRS_APB_IDLE,
      TMRS_APB_SETUP,
      TMRS_APB_ACCESS
   } tmrs_apb_type;
endpackage

// [hw/tmrs_top.sv]
// timer/counter register set with shared prescaler/watchdog, apb slave
// assumes a 10 MHz clock; the external count pin is asynchronous
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "tmrs_consts.svh"
module tmrs_top #(
   parameter int WD_BASE_CYCLES = `TMRS_WD_BASE_NS / `TMRS_CLK_NS
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        count_pin,
   output logic             irq,
   output logic             watchdog_reset,
   output logic [4:0]       port_a_direction
);
   // a base period under two cycles leaves the tick compare with no room to count
   if (WD_BASE_CYCLES < 2) begin : g_bad_base
      $error("watchdog base period too short");
   end

   ////////////////////////////////////////////////////////////////////////
   // reset release and pin synchroniser
   logic       rst_meta_q;
   logic       rst_sync_q;
   logic       rst_n;
   logic [1:0] pin_sync_q;
   logic       pin_prev_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_q <= 2'h0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[0], count_pin};
         pin_prev_q <= pin_sync_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   function automatic logic is_idx(input logic [11:0] a, input logic [7:0] idx);
      return a == {2'h0, idx, 2'h0};
   endfunction

   tmrs_pkg::tmrs_apb_type apb_q;
   tmrs_pkg::tmrs_apb_type apb_d;
   logic access_w;
   logic wr_w;
   logic rd_w;
   // ready only follows a seen setup, so the phase check keeps a stray ready harmless
   assign access_w = psel && penable && pready && (apb_q == tmrs_pkg::TMRS_APB_SETUP);
   assign wr_w     = access_w && pwrite;
   assign rd_w     = access_w && !pwrite;

   logic hit_count;
   logic hit_ic;
   logic hit_opt;
   logic hit_dir;
   logic hit_ctl;
   logic hit_stat;
   logic hit_mask;
   assign hit_count = is_idx(paddr, `TMRS_IDX_COUNT);
   assign hit_ic    = is_idx(paddr, `TMRS_IDX_INTCTL_LO) || is_idx(paddr, `TMRS_IDX_INTCTL_HI);
   assign hit_opt   = is_idx(paddr, `TMRS_IDX_OPTIONS);
   assign hit_dir   = is_idx(paddr, `TMRS_IDX_DIR);
   assign hit_ctl   = is_idx(paddr, `TMRS_IDX_CONTROL);
   assign hit_stat  = is_idx(paddr, `TMRS_IDX_STATUS);
   assign hit_mask  = is_idx(paddr, `TMRS_IDX_MASK);
   logic hit_any;
   assign hit_any = hit_count | hit_ic | hit_opt | hit_dir | hit_ctl | hit_stat | hit_mask;

   // bus phase as sampled at the coming edge; ready answers one cycle after setup
   always_comb begin
      if (!psel) begin
         apb_d = tmrs_pkg::TMRS_APB_IDLE;
      end else if (!penable) begin
         apb_d = tmrs_pkg::TMRS_APB_SETUP;
      end else begin
         apb_d = tmrs_pkg::TMRS_APB_ACCESS;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0]  count_q;
   logic [7:0]  count_d;
   logic [7:0]  ic_q;
   logic [7:0]  ic_d;
   logic [7:0]  opt_q;
   logic [7:0]  opt_d;
   logic [4:0]  dir_q;
   logic [4:0]  dir_d;
   logic [7:0]  pre_q;
   logic [7:0]  pre_d;
   logic [1:0]  inhibit_q;
   logic [1:0]  inhibit_d;
   logic [31:0] wd_base_q;
   logic [31:0] wd_base_d;
   logic        wd_rst_q;
   logic        wd_rst_d;
   logic [1:0]  stat_q;
   logic [1:0]  stat_d;
   logic [1:0]  mask_q;
   logic [1:0]  mask_d;
   logic        por_q;
   logic        por_d;
   logic        pready_q;
   logic        pready_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic        irq_q;
   logic        irq_d;

   logic        wd_clear;
   logic        count_wr;
   logic        src_tick;
   logic        pre_out;
   logic        timer_tick;
   logic        ovf;
   logic        wd_tick;
   logic [7:0]  ratio_mask;
   logic [31:0] rdata_w;

   ////////////////////////////////////////////////////////////////////////
   // count source and prescaler taps
   always_comb begin
      wd_clear   = wr_w && hit_ctl && pwdata[`TMRS_CTL_WD_CLEAR];
      count_wr   = wr_w && hit_count;
      // instruction clock or chosen pin edge
      src_tick   = opt_q[`TMRS_OPT_SRC]
                 ? (opt_q[`TMRS_OPT_EDGE] ? (pin_prev_q && !pin_sync_q[1])
                                          : (!pin_prev_q && pin_sync_q[1]))
                 : 1'b1;
      // ratio 1:2 .. 1:256 as low bits all set
      ratio_mask = 8'hff >> (3'd7 - opt_q[2:0]);
      pre_out    = (pre_q & ratio_mask) == ratio_mask;
      timer_tick = opt_q[`TMRS_OPT_ASSIGN] ? src_tick : (src_tick && pre_out);
      ovf        = timer_tick && (inhibit_q == 2'h0) && (count_q == 8'hff) && !count_wr;
      wd_tick    = wd_base_q == 32'(WD_BASE_CYCLES - 1);
   end

   ////////////////////////////////////////////////////////////////////////
   // count register and shared prescaler
   // a count write wins over a pending increment and, while the prescaler is on the timer, restarts it
   always_comb begin
      count_d   = count_q;
      inhibit_d = (inhibit_q != 2'h0) ? inhibit_q - 2'h1 : 2'h0;
      pre_d     = pre_q;
      if (count_wr) begin
         count_d   = pwdata[7:0];
         inhibit_d = 2'h2;
      end else if (timer_tick && inhibit_q == 2'h0) begin
         count_d = count_q + 8'h01;
      end
      if (!opt_q[`TMRS_OPT_ASSIGN]) begin
         if (count_wr) pre_d = 8'h00;
         else if (src_tick) pre_d = pre_q + 8'h01;
      end else begin
         if (wd_clear) pre_d = 8'h00;
         else if (wd_tick) pre_d = pre_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog base counter and timeout pulse
   always_comb begin
      wd_base_d = wd_tick ? 32'h0000_0000 : wd_base_q + 32'h0000_0001;
      wd_rst_d  = 1'b0;
      if (wd_clear) begin
         wd_base_d = 32'h0000_0000;
      end else if (wd_tick) begin
         // watchdog without prescaler fires every base period
         if (!opt_q[`TMRS_OPT_ASSIGN] || pre_out) wd_rst_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software writes; hardware set wins over a clear in the same cycle
   always_comb begin
      ic_d   = ic_q;
      opt_d  = opt_q;
      dir_d  = dir_q;
      stat_d = stat_q;
      mask_d = mask_q;
      por_d  = por_q;
      if (wr_w && hit_ic)  ic_d  = pwdata[7:0];
      if (wr_w && hit_opt) opt_d = pwdata[7:0];
      if (wr_w && hit_dir) dir_d = pwdata[4:0];
      if (wr_w && hit_mask) mask_d = pwdata[1:0];
      if (wr_w && hit_stat) stat_d = stat_q & ~pwdata[1:0];
      if (wr_w && hit_ctl && pwdata[`TMRS_CTL_POR]) por_d = 1'b1;
      if (ovf) begin
         ic_d[`TMRS_IC_OVF_FLAG] = 1'b1;
         stat_d[`TMRS_EV_OVF]    = 1'b1;
      end
      if (wd_rst_q) stat_d[`TMRS_EV_WD] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux and bus answer
   always_comb begin
      rdata_w = 32'h0000_0000;
      if (hit_count) rdata_w[7:0] = count_q;
      if (hit_ic)    rdata_w[7:0] = ic_q;
      if (hit_opt)   rdata_w[7:0] = opt_q;
      if (hit_dir)   rdata_w[4:0] = dir_q;
      if (hit_stat)  rdata_w[1:0] = stat_q;
      if (hit_mask)  rdata_w[1:0] = mask_q;
      // no wait state; read data is registered during setup
      pready_d  = (apb_d == tmrs_pkg::TMRS_APB_SETUP);
      prdata_d  = (psel && !penable && !pwrite) ? rdata_w : prdata_q;
      pslverr_d = psel && !penable && !hit_any;
      if (rd_w) prdata_d = prdata_q;
      irq_d = |(stat_d & mask_d);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   // count keeps its value on every reset but power-on, which is a write of one to control bit 1
   // no reset here: the count must survive every reset but the power-on strobe
   always_ff @(posedge clock) begin
      if (por_q) begin
         count_q <= 8'h00;
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ic_q      <= `TMRS_IC_RESET;
         opt_q     <= `TMRS_OPT_RESET;
         dir_q     <= `TMRS_DIR_RESET;
         pre_q     <= 8'h00;
         inhibit_q <= 2'h0;
         wd_base_q <= 32'h0000_0000;
         apb_q     <= tmrs_pkg::TMRS_APB_IDLE;
         wd_rst_q  <= 1'b0;
         stat_q    <= 2'h0;
         mask_q    <= 2'h0;
         por_q     <= 1'b0;
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         ic_q      <= ic_d;
         opt_q     <= opt_d;
         dir_q     <= dir_d;
         pre_q     <= pre_d;
         inhibit_q <= inhibit_d;
         wd_base_q <= wd_base_d;
         apb_q     <= apb_d;
         wd_rst_q  <= wd_rst_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
         por_q     <= por_d & ~por_q;
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
         irq_q     <= irq_d;
      end
   end

   assign pready           = pready_q;
   assign prdata           = prdata_q;
   assign pslverr          = pslverr_q;
   assign irq              = irq_q;
   assign watchdog_reset   = wd_rst_q;
   assign port_a_direction = dir_q;
endmodule // tmrs_top

// [testbench/tmrs_monitor.sv]
// port checker for the timer register set
// assumes bind onto tmrs_top, one clock domain
`timescale 1ns/1ps
module tmrs_monitor #(parameter int WD_BASE_CYCLES = 4) (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        count_pin,
   input wire logic        irq,
   input wire logic        watchdog_reset,
   input wire logic [4:0]  port_a_direction
);
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic mapped;
   assign mapped = paddr inside {12'h004, 12'h02c, 12'h22c, 12'h204, 12'h214, 12'h300,
      12'h304, 12'h308};
   sequence setup_s; psel && !penable; endsequence
   sequence take_s; psel && penable && pready; endsequence
   chk_ready_next: assert property (setup_s |=> pready) else $error("no ready after setup");
   chk_ready_alone: assert property (pready |-> psel && penable) else $error("stray ready");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   chk_err_unmapped: assert property (take_s |-> pslverr == !mapped) else $error("bad slverr");
   chk_upper_zero: assert property (take_s ##0 !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   chk_dir_unimpl: assert property (take_s ##0 !pwrite && paddr == 12'h214 |->
      prdata[7:5] == 3'h0) else $error("direction spare bits set");
   chk_dir_write: assert property (take_s ##0 pwrite && paddr == 12'h214 |=>
      port_a_direction == $past(pwdata[4:0])) else $error("direction not updated");
   chk_dir_reset: assert property ($rose(rstn) |-> port_a_direction == 5'h1f)
      else $error("direction reset wrong");
   chk_wd_pulse: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("watchdog pulse too long");
endmodule // tmrs_monitor
bind tmrs_top tmrs_monitor #(.WD_BASE_CYCLES(WD_BASE_CYCLES)) u_mon (.clock(clock),
   .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .count_pin(count_pin), .irq(irq), .watchdog_reset(watchdog_reset),
   .port_a_direction(port_a_direction));

// [testbench/tmrs_top_tb.sv]
// self-checking bench for the timer register set
// assumes tmrs_top and its bound checker; apb reads are queued and compared
`timescale 1ns/1ps
module tmrs_top_tb;
   logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, count_pin = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, irq, watchdog_reset;
   logic [4:0]  port_a_direction;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [7:0]  v;
   int          n_mismatch = 0, total_checks = 0, seed = 32'h1a2d_37d6, n_wd = 0;
   always #50 clock = ~clock;
   // short watchdog base keeps timeouts inside the run
   tmrs_top #(.WD_BASE_CYCLES(4)) dut (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .count_pin(count_pin), .irq(irq),
      .watchdog_reset(watchdog_reset), .port_a_direction(port_a_direction));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // for reads d is the expected byte, er the expected slverr
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic er);
      int n;
      n = 0;
      if (!w) exp_q.push_back({er, 24'h00_0000, d});
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk_irq(input logic x);
      total_checks++;
      if (irq !== x) begin n_mismatch++; $display("CHECK FAILED %0t irq", $time); end
   endtask
   always @(posedge clock) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         total_checks++;
         e = exp_q.size() ? exp_q.pop_front() : 33'hx;
         if ({pslverr, prdata} !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t read %h got %h", $time, e, {pslverr, prdata});
         end
      end
   end
   initial begin
      #500000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      apb(0, 12'h204, 8'hff, 0);
      apb(0, 12'h214, 8'h1f, 0);
      apb(0, 12'h02c, 8'h00, 0);
      apb(1, 12'h300, 8'h02, 0);
      apb(0, 12'h004, 8'h00, 0);
      v = $random(seed);
      apb(1, 12'h22c, v, 0);
      apb(0, 12'h02c, v, 0);
      apb(1, 12'h214, v, 0);
      apb(0, 12'h214, {3'h0, v[4:0]}, 0);
      apb(1, 12'h3fc, v, 0);
      apb(0, 12'h3fc, 8'h00, 1);
      apb(1, 12'h02c, 8'h20, 0);
      apb(1, 12'h300, 8'h01, 0);
      apb(1, 12'h204, 8'h00, 0);
      apb(1, 12'h004, 8'hfe, 0);
      // timer owns the prescaler: watchdog fires once per 4-cycle base period
      n_wd = 0;
      repeat (40) begin
         @(posedge clock);
         if (watchdog_reset === 1'b1) n_wd++;
      end
      total_checks++;
      if (n_wd != 10) begin n_mismatch++; $display("CHECK FAILED %0t watchdog", $time); end
      apb(0, 12'h02c, 8'h24, 0);
      chk_irq(0);
      apb(1, 12'h308, 8'h01, 0);
      repeat (2) @(posedge clock);
      chk_irq(1);
      apb(1, 12'h304, 8'h01, 0);
      repeat (2) @(posedge clock);
      chk_irq(0);
      // rising then falling pin edge, in each edge mode
      for (int s = 0; s < 2; s++) begin
         apb(1, 12'h204, s ? 8'h38 : 8'h28, 0);
         apb(1, 12'h004, 8'h00, 0);
         repeat (4) @(posedge clock);
         count_pin <= 1'b1;
         repeat (8) @(posedge clock);
         apb(0, 12'h004, s ? 8'h00 : 8'h01, 0);
         count_pin <= 1'b0;
         repeat (8) @(posedge clock);
         apb(0, 12'h004, 8'h01, 0);
      end
      end_sim();
   end
endmodule // tmrs_top_tb
